/* src/sct_capture_ctrl.sv */
// sct_capture_ctrl: acquisition write and trigger sequencing with Avalon-MM registers
// assumes sample and trigger inputs come from logic on sys_clk
//
// Overview of operation
// - next segment trigger watched right after trigger
// - next segment starts at fill end or trigger
// - pre position: tenth before, nine tenths after
// - one position setting for all segments
// - three modes: continuous, qualified, segmented
// - continuous mode fills memory before triggering
// - readout refused until a run starts; in continuous mode until memory filled once
// - segmented and qualified evaluate triggers immediately
// - early trigger accepted, only post data follows
// - post position captures twelve percent after trigger
// - post amount twelve, fifty, eighty-eight or ninety percent
// - each segment an independent buffer, then advance
`timescale 1ns/10ps
module sct_capture_ctrl
    import sct_pkg::*;
#(
    parameter int unsigned AW    = 8,
    parameter int unsigned DW    = 16,
    parameter int unsigned NSEGS = 4
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // sampled user logic
    input  wire logic [DW-1:0]         sampleData,
    input  wire logic                  sampleQual,
    input  wire logic [NSEGS-1:0]      segTrigger,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]     avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [DATA_W-1:0]     avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [DATA_W-1:0]     avs_readdata,
    output logic                       avs_waitrequest,
    // interrupt
    output logic                       irq
);
    import sct_pkg::*;

    localparam int unsigned SEG_MAX = 1 << CTRL_SEG_W;
    localparam int unsigned CW      = AW + 1;

    typedef struct packed {
        sct_state_t          fsm;
        logic [31:0]         ctrl;
        logic [IRQ_W-1:0]    irqStat;
        logic [IRQ_W-1:0]    irqMask;
        logic [AW-1:0]       rdAddr;
        logic [AW-1:0]       wrPtr;
        logic [AW-1:0]       segBase;
        logic [AW-1:0]       trigAddr;
        logic [CW-1:0]       fillCnt;
        logic [CW-1:0]       postCnt;
        logic [CW-1:0]       totalCnt;
        logic [CTRL_SEG_W-1:0] segIdx;
        logic                filledOnce;
        logic                done;
        logic                refused;
        logic                rdPend;
        logic                ack;
        logic [DATA_W-1:0]   rdData;
        logic                irqOut;
    } sct_regs_t;

    sct_regs_t state_reg, state_next;
    sct_mem_if #(.AW(AW), .DW(DW)) memPort ();

    sct_sample_mem #(.AW(AW), .DW(DW)) u_mem (
        .sys_clk (sys_clk),
        .port    (memPort)
    );

    // post-trigger length for a window of the given size
    function automatic logic [CW-1:0] postLen(input sct_pos_t pos, input logic [CW-1:0] win);
        logic [CW+7:0] prod;
        prod = '0;
        case (pos)
            POS_PRE:    prod = (CW+8)'(win) * (CW+8)'(PCT_PRE);
            POS_CENTER: prod = (CW+8)'(win) * (CW+8)'(PCT_CENTER);
            POS_POST:   prod = (CW+8)'(win) * (CW+8)'(PCT_POST);
            default:    prod = (CW+8)'(win) * (CW+8)'(PCT_FULLPOST);
        endcase
        postLen = CW'(prod / (CW+8)'(PCT_FULL));
        if (postLen == '0)
        begin
            postLen = CW'(1);
        end
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    sct_mode_t              mode;
    sct_pos_t               pos;
    logic [CTRL_SEG_W-1:0]  segLast;
    logic [CW-1:0]          segLen;
    logic [CW-1:0]          depth;
    logic                   curTrig;
    logic                   nextTrig;
    logic                   lastSeg;
    logic                   canWrite;
    logic                   access;
    logic [31:0]            wMask;
    logic [IRQ_W-1:0]       irqSet;

    assign mode    = sct_mode_t'(state_reg.ctrl[CTRL_MODE_LSB +: 2]);
    assign pos     = sct_pos_t'(state_reg.ctrl[CTRL_POS_LSB +: 2]);
    assign segLast = (mode == MODE_SEG) ? state_reg.ctrl[CTRL_SEG_LSB +: CTRL_SEG_W]
                                        : '0;
    assign depth   = CW'(1) << AW;
    assign segLen  = depth >> ((mode == MODE_SEG) ? 32'(segLast != '0 ? $clog2(32'(segLast) + 1) : 0) : 0);
    assign lastSeg = (state_reg.segIdx == segLast);
    assign curTrig = segTrigger[state_reg.segIdx % NSEGS];
    assign nextTrig = !lastSeg && segTrigger[(state_reg.segIdx + 1'b1) % NSEGS];
    assign canWrite = (mode != MODE_QUAL) || sampleQual;
    assign access   = (avs_read || avs_write) && !state_reg.ack;

    assign memPort.wrData = sampleData;
    assign memPort.rdAddr = state_reg.rdAddr;
    assign memPort.wrAddr = state_reg.segBase + state_reg.wrPtr;
    assign memPort.wrEn   = canWrite && (state_reg.fsm == ST_PREFILL || state_reg.fsm == ST_ARMED
                                         || state_reg.fsm == ST_POSTF);

    always_comb
    begin
        state_next = state_reg;
        irqSet     = '0;
        wMask      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        state_next.ack    = access;
        state_next.rdPend = 1'b0;
        // capture sequencing
        case (state_reg.fsm)
            ST_IDLE:
            begin
                if (state_reg.ctrl[CTRL_RUN])
                begin
                    state_next.wrPtr    = '0;
                    state_next.segBase  = '0;
                    state_next.segIdx   = '0;
                    state_next.fillCnt  = '0;
                    state_next.totalCnt = '0;
                    state_next.done     = 1'b0;
                    state_next.filledOnce = (mode != MODE_CONT);
                    state_next.ctrl[CTRL_RUN] = 1'b0;
                    state_next.fsm = (mode == MODE_CONT) ? ST_PREFILL : ST_ARMED;
                end
            end
            ST_PREFILL:
            begin
                // continuous mode: a full memory before triggers count
                state_next.wrPtr   = state_reg.wrPtr + 1'b1;
                state_next.fillCnt = state_reg.fillCnt + 1'b1;
                if (state_reg.fillCnt == depth - 1'b1)
                begin
                    state_next.filledOnce = 1'b1;
                    state_next.fsm = ST_ARMED;
                end
                if (state_reg.ctrl[CTRL_STOP])
                begin
                    // stop before first fill leaves memory unreadable
                    state_next.ctrl[CTRL_STOP] = 1'b0;
                    state_next.fsm = ST_IDLE;
                end
            end
            ST_ARMED:
            begin
                if (canWrite)
                begin
                    state_next.wrPtr = AW'((CW'(state_reg.wrPtr) + 1'b1) % segLen);
                end
                // trigger wins over pre-trigger collection
                if (curTrig)
                begin
                    state_next.trigAddr = memPort.wrAddr;
                    state_next.postCnt  = postLen(pos, segLen);
                    irqSet[IRQ_TRIG]    = 1'b1;
                    state_next.fsm      = ST_POSTF;
                end
                if (state_reg.ctrl[CTRL_STOP])
                begin
                    state_next.ctrl[CTRL_STOP] = 1'b0;
                    state_next.fsm = ST_FIN;
                end
            end
            ST_POSTF:
            begin
                if (canWrite)
                begin
                    state_next.wrPtr   = AW'((CW'(state_reg.wrPtr) + 1'b1) % segLen);
                    state_next.postCnt = state_reg.postCnt - 1'b1;
                end
                // next segment at fill end or on its trigger
                if ((canWrite && state_reg.postCnt == CW'(1)) || nextTrig)
                begin
                    if (lastSeg)
                    begin
                        state_next.fsm = ST_FIN;
                    end
                    else
                    begin
                        // fresh independent segment
                        state_next.segIdx  = state_reg.segIdx + 1'b1;
                        state_next.segBase = AW'(CW'(state_reg.segBase) + segLen);
                        state_next.wrPtr   = '0;
                        state_next.fsm     = ST_ARMED;
                    end
                end
            end
            ST_FIN:
            begin
                state_next.done  = 1'b1;
                irqSet[IRQ_DONE] = 1'b1;
                state_next.fsm   = ST_IDLE;
            end
            default:
            begin
                state_next.fsm = ST_IDLE;
            end
        endcase

        // register access, one wait state then answer
        if (access && avs_write)
        begin
            if (hit(avs_address, OFF_CTRL))
            begin
                state_next.ctrl = (state_reg.ctrl & ~wMask) | (avs_writedata & wMask);
            end
            if (hit(avs_address, OFF_IRQ_MASK))
            begin
                state_next.irqMask = IRQ_W'(avs_writedata & wMask);
            end
            if (hit(avs_address, OFF_IRQ_STAT))
            begin
                state_next.irqStat = state_reg.irqStat & ~IRQ_W'(avs_writedata & wMask);
            end
            if (hit(avs_address, OFF_RD_ADDR))
            begin
                state_next.rdAddr = AW'(avs_writedata & wMask);
            end
        end
        if (access && avs_read)
        begin
            state_next.rdData  = READ_ZERO;
            state_next.refused = 1'b0;
            if (hit(avs_address, OFF_CTRL))
                state_next.rdData = state_reg.ctrl;
            if (hit(avs_address, OFF_STATUS))
                state_next.rdData = 32'({state_reg.refused, state_reg.fsm != ST_IDLE,
                                         state_reg.filledOnce, state_reg.done});
            if (hit(avs_address, OFF_IRQ_STAT))
                state_next.rdData = 32'(state_reg.irqStat);
            if (hit(avs_address, OFF_IRQ_MASK))
                state_next.rdData = 32'(state_reg.irqMask);
            if (hit(avs_address, OFF_RD_ADDR))
                state_next.rdData = 32'(state_reg.rdAddr);
            if (hit(avs_address, OFF_TRIG_ADDR))
                state_next.rdData = 32'(state_reg.trigAddr);
            if (hit(avs_address, OFF_RD_DATA))
            begin
                if (state_reg.filledOnce)
                begin
                    state_next.rdData = 32'(memPort.rdData);
                end
                else
                begin
                    state_next.refused  = 1'b1;
                    irqSet[IRQ_REFUSE] = 1'b1;
                end
            end
        end
        // hardware set wins over software clear
        state_next.irqStat = state_next.irqStat | irqSet;
        state_next.irqOut  = |(state_next.irqStat & state_next.irqMask);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg      <= '0;
            state_reg.fsm  <= ST_IDLE;
            state_reg.ctrl <= CTRL_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata    = state_reg.rdData;
    assign avs_waitrequest = !state_reg.ack;
    assign irq             = state_reg.irqOut;
endmodule // sct_capture_ctrl

/* inc/sct_pkg.sv */
// sct_pkg: register map, field positions, modes and fractions of the capture controller
// assumes a 32-bit Avalon-MM slave word addressing by byte offset
package sct_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_STATUS     = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h0C;
    localparam logic [7:0] OFF_RD_ADDR    = 8'h10;
    localparam logic [7:0] OFF_RD_DATA    = 8'h14;
    localparam logic [7:0] OFF_TRIG_ADDR  = 8'h18;
    // control fields
    localparam int unsigned CTRL_RUN      = 0;
    localparam int unsigned CTRL_STOP     = 1;
    localparam int unsigned CTRL_MODE_LSB = 4;
    localparam int unsigned CTRL_POS_LSB  = 8;
    localparam int unsigned CTRL_SEG_LSB  = 12;
    localparam int unsigned CTRL_SEG_W    = 3;
    // status / irq bits
    localparam int unsigned ST_DONE       = 0;
    localparam int unsigned ST_FILLED     = 1;
    localparam int unsigned ST_BUSY       = 2;
    localparam int unsigned ST_REFUSED    = 3;
    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_DONE      = 0;
    localparam int unsigned IRQ_TRIG      = 1;
    localparam int unsigned IRQ_REFUSE    = 2;
    // reset values
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
    // post-trigger fractions, percent of the capture window (segment length in segmented mode)
    localparam int unsigned PCT_PRE       = 90;
    localparam int unsigned PCT_CENTER    = 50;
    localparam int unsigned PCT_POST      = 12;
    localparam int unsigned PCT_FULL      = 100;
    localparam int unsigned PCT_FULLPOST  = 88;

    typedef enum logic [1:0]
    {
        MODE_CONT = 2'b00,
        MODE_QUAL = 2'b01,
        MODE_SEG  = 2'b10
    } sct_mode_t;

    typedef enum logic [1:0]
    {
        POS_PRE    = 2'b00,
        POS_CENTER = 2'b01,
        POS_POST   = 2'b10
    } sct_pos_t;

    typedef enum logic [4:0]
    {
        ST_IDLE    = 5'b00001,
        ST_PREFILL = 5'b00010,
        ST_ARMED   = 5'b00100,
        ST_POSTF   = 5'b01000,
        ST_FIN     = 5'b10000
    } sct_state_t;
endpackage

/* inc/sct_mem_if.sv */
// sct_mem_if: write and read ports between the controller and its sample memory
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface sct_mem_if #(parameter int unsigned AW = 8, parameter int unsigned DW = 16);
    logic          wrEn;
    logic [AW-1:0] wrAddr;
    logic [DW-1:0] wrData;
    logic [AW-1:0] rdAddr;
    logic [DW-1:0] rdData;
    modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

/* src/sct_sample_mem.sv */
// sct_sample_mem: acquisition memory, one write and one registered read port
// assumes the controller keeps addresses inside the depth
`timescale 1ns/10ps
module sct_sample_mem #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 16
) (
    // clock
    input wire logic sys_clk,
    // memory port
    sct_mem_if.mem   port
);
    logic [DW-1:0] storeArr [0:(1<<AW)-1];
    logic [DW-1:0] rdData_reg;

    always_ff @(posedge sys_clk)
    begin
        if (port.wrEn)
        begin
            storeArr[port.wrAddr] <= port.wrData;
        end
        rdData_reg <= storeArr[port.rdAddr];
    end

    assign port.rdData = rdData_reg;
endmodule // sct_sample_mem

/* sim/sct_user_src.sv */
// sct_user_src: model of the sampled user logic feeding the capture controller
// assumes the bench steers trigger and qualifier levels on sys_clk
`timescale 1ns/10ps
module sct_user_src #(
    parameter int unsigned DW    = 16,
    parameter int unsigned NSEGS = 4
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // bench control
    input  wire logic [NSEGS-1:0] trigEn,
    input  wire logic             qualEn,
    // toward the controller
    output logic      [DW-1:0]    sampleData,
    output logic                  sampleQual,
    output logic      [NSEGS-1:0] segTrigger
);
    // free running count, so every stored sample tells when it was taken
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sampleData <= '0;
            segTrigger <= '0;
            sampleQual <= 1'b0;
        end
        else
        begin
            sampleData <= sampleData + 1'b1;
            segTrigger <= trigEn;
            sampleQual <= qualEn;
        end
    end
endmodule // sct_user_src

/* sim/sct_capture_chk.sv */
// sct_capture_chk: port level checks of the capture controller
// assumes it is bound to sct_capture_ctrl and sees only its ports
`timescale 1ns/10ps
module sct_capture_chk #(
    parameter int unsigned DW    = 16,
    parameter int unsigned NSEGS = 4
) (
    input wire logic                      sys_clk,
    input wire logic                      resetn,
    input wire logic [DW-1:0]             sampleData,
    input wire logic                      sampleQual,
    input wire logic [NSEGS-1:0]          segTrigger,
    input wire logic [sct_pkg::ADDR_W-1:0] avs_address,
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [sct_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0]                avs_byteenable,
    input wire logic [sct_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                      avs_waitrequest,
    input wire logic                      irq
);
    import sct_pkg::*;
    logic [IRQ_W-1:0] maskReg;
    // shadow of the interrupt mask, taken at the edge that takes the write
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            maskReg <= '0;
        else if (avs_waitrequest && avs_write && avs_address == OFF_IRQ_MASK
                 && avs_byteenable[0])
            maskReg <= avs_writedata[IRQ_W-1:0];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence reqTaken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answered;
        !avs_waitrequest;
    endsequence
    a_ack_latency: assert property (reqTaken |=> answered)
        else $error("request not answered after one wait state");
    a_ack_single: assert property (answered |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    a_ack_cause: assert property (answered |-> $past(avs_read || avs_write))
        else $error("answer not caused by a request");
    a_rdata_hold: assert property (!(!avs_waitrequest && avs_read) |-> $stable(avs_readdata))
        else $error("read data moved outside a read answer");
    a_unmapped_zero: assert property (answered and (avs_read && avs_address >= 8'h1C)
        |-> avs_readdata == READ_ZERO)
        else $error("unmapped read not zero");
    a_status_spare: assert property (answered and (avs_read && avs_address == OFF_STATUS)
        |-> avs_readdata[31:4] == 28'h000_0000)
        else $error("spare status bits set");
    a_irq_masked: assert property ((maskReg == '0) [*3] |-> !irq)
        else $error("interrupt raised while fully masked");
    cover property (answered and (avs_read && avs_address == OFF_RD_DATA));
endmodule // sct_capture_chk

/* sim/sct_capture_ctrl_test.sv */
// sct_capture_ctrl_test: register level tests of the capture controller
// assumes the user source model and the bound checker are compiled with it
`timescale 1ns/10ps
module sct_capture_ctrl_test;
    import sct_pkg::*;
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic [15:0] sampleData, d;
    logic        sampleQual, qualEn, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0]  segTrigger, trigEn, avs_byteenable;
    logic [7:0]  avs_address, t;
    logic [31:0] avs_writedata, avs_readdata, rdq;
    int          errors, checkCount, cyc;
    always #10 sys_clk = ~sys_clk;
    sct_user_src u_src (.sys_clk(sys_clk), .resetn(resetn), .trigEn(trigEn), .qualEn(qualEn),
        .sampleData(sampleData), .sampleQual(sampleQual), .segTrigger(segTrigger));
    sct_capture_ctrl u_dut (.sys_clk(sys_clk), .resetn(resetn), .sampleData(sampleData),
        .sampleQual(sampleQual), .segTrigger(segTrigger), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    task check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= dat;
        do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 100);
        if (avs_waitrequest !== 1'b0)
            errors++;
        rdq = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task mem_rd(input logic [7:0] a);
        bus(1'b1, OFF_RD_ADDR, {24'h00_0000, a});
        repeat (2) @(posedge sys_clk);
        bus(1'b0, OFF_RD_DATA, 32'h0000_0000);
    endtask
    // stored sample at trigger address plus off must be trigger sample plus dOff
    task cmem(input logic [7:0] off, input logic [15:0] dOff);
        mem_rd(8'(t + off));
        check({16'h0000, rdq[15:0]}, {16'h0000, 16'(d + dOff)});
    endtask
    task run_wait(input logic [31:0] c);
        time t0;
        int  n;
        bus(1'b1, OFF_CTRL, c);
        t0 = $time;
        n  = 0;
        do begin bus(1'b0, OFF_STATUS, 32'h0000_0000); n++; end
        while (rdq[ST_DONE] !== 1'b1 && n < 2000);
        cyc = int'(($time - t0) / 20);
        check({31'h0, rdq[ST_DONE]}, 32'h0000_0001);
        bus(1'b0, OFF_TRIG_ADDR, 32'h0000_0000);
        t = rdq[7:0];
        mem_rd(t);
        d = rdq[15:0];
    endtask
    task complete_run;
        $display("checks %0d, mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        errors++;
        complete_run();
    end
    initial
    begin
        errors = 0;
        checkCount = 0;
        {avs_read, avs_write, avs_address, avs_writedata} <= '0;
        avs_byteenable <= 4'hF;
        trigEn <= 4'h1;
        qualEn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        bus(1'b0, OFF_CTRL, 32'h0000_0000);
        check(rdq, CTRL_RESET);
        bus(1'b0, 8'h1C, 32'h0000_0000);
        check(rdq, READ_ZERO);
        // stop while prefilling: nothing may be read out
        bus(1'b1, OFF_CTRL, 32'h0000_0001);
        repeat (50) @(posedge sys_clk);
        bus(1'b1, OFF_CTRL, 32'h0000_0002);
        repeat (3) @(posedge sys_clk);
        bus(1'b0, OFF_STATUS, 32'h0000_0000);
        check(rdq & 32'h0000_0007, 32'h0000_0000);
        mem_rd(8'h00);
        check(rdq, READ_ZERO);
        bus(1'b0, OFF_STATUS, 32'h0000_0000);
        check(rdq & 32'h0000_0008, 32'h0000_0008);
        bus(1'b0, OFF_IRQ_STAT, 32'h0000_0000);
        check(rdq & 32'h0000_0004, 32'h0000_0004);
        check({31'h0, irq}, 32'h0000_0000);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0004);
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0001);
        bus(1'b1, OFF_IRQ_STAT, 32'h0000_0004);
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0000);
        // continuous, post position, trigger held high from the start
        run_wait(32'h0000_0201);
        check({31'h0, cyc >= 280}, 32'h0000_0001);
        cmem(8'd29, 16'd29);
        cmem(8'd31, 16'hFF1F);
        // qualified, centre position, trigger before any pre data
        run_wait(32'h0000_0111);
        check({31'h0, cyc < 200}, 32'h0000_0001);
        cmem(8'd1, 16'd1);
        cmem(8'd126, 16'd126);
        // segmented, pre position, four segments all triggering at once
        trigEn <= 4'hF;
        run_wait(32'h0000_3021);
        check({31'h0, cyc < 120}, 32'h0000_0001);
        check({30'h0, t[7:6]}, 32'h0000_0003);
        cmem(8'd56, 16'd56);
        complete_run();
    end
endmodule // sct_capture_ctrl_test
bind sct_capture_ctrl sct_capture_chk #(.DW(DW), .NSEGS(NSEGS)) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .sampleData(sampleData), .sampleQual(sampleQual),
    .segTrigger(segTrigger), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
